// ---- mrr_mem_return.sv ----
// Memory end: read return path from bank stack to one CPU port
//
// Summary of operation
// - Destination code comes from request write data
// - CPU disposes data by destination code
// - Two-bit return path travels with reference
// - Steer by return path, replace with bank
// - Report seven-bit bank number per response
// - Bank bits four to six forced zero
// - Bank bits 1:0 forced from group
// - CPU decodes bank bits for error reporting
// - Stack delivers 76 bits, 64 data 12 check
// - Spare chip shift undone on reads
// - Halves split lower and upper bit sets
// - CPU places destination halves in write data
// - CPU strobes each request half separately
// - Separate valid out and resume per half
// - Bank, steer, port slices in order
// - Subsection return info comes back with response
`timescale 1ns/1ps
`include "mrr_map.svh"
module mrr_mem_return #(
    parameter logic [1:0] PORT_ID = 2'h0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic stack_valid,
    output logic stack_ready,
    input wire mrr_pkg::mrr_word_t stack_word,
    input wire mrr_pkg::mrr_group_t stack_group,
    input wire logic [1:0] stack_bank_hi,
    input wire mrr_pkg::mrr_rpath_t stack_rpath,
    input wire mrr_pkg::mrr_ss_t stack_ss,
    input wire logic [`MRR_DEST_W-1:0] stack_wdata_dest,
    input wire mrr_pkg::mrr_spare_t spare_pos,
    mrr_link_if.mem link
);
    import mrr_pkg::*;
    localparam int FW = `MRR_WORD_W + `MRR_DEST_W + `MRR_BANK_W + `MRR_SS_W;

    // ==========================================
    // Bank slice: unshift around spared chip
    // Position all ones means no chip is spared
    wire spare_active = (spare_pos != `MRR_SPARE_NONE);
    logic [`MRR_WORD_W-1:0] fixed_word;
    genvar gi;
    generate
        for (gi = 0; gi < `MRR_WORD_W; gi++) begin : g_unshift
            if (gi == `MRR_WORD_W-1) begin : g_top
                assign fixed_word[gi] = stack_word[gi];
            end else begin : g_mid
                // Bits at and above the bad chip move down one place
                assign fixed_word[gi] = (spare_active && 7'(gi) >= spare_pos)
                    ? stack_word[gi+1] : stack_word[gi];
            end
        end
    endgenerate

    // ==========================================
    // Steer slice: select port by return path
    wire for_me = (stack_rpath == PORT_ID);
    // The return path bits stop here; only the match travels on
    wire take = stack_valid && for_me;

    // ==========================================
    // Bank number: rebuild bits the request dropped
    // Bank bits 1:0 never travel with the data; each group forces its own
    wire forced_bank0_group0 = 1'b0;
    wire forced_bank1_group0 = 1'b0;
    wire forced_bank0_group1 = 1'b1;
    wire forced_bank1_group1 = 1'b0;
    wire forced_bank0_group2 = 1'b0;
    wire forced_bank1_group2 = 1'b1;
    wire forced_bank0_group3 = 1'b1;
    wire forced_bank1_group3 = 1'b1;
    wire [1:0] forced_bank = (stack_group == 2'h0) ? {forced_bank1_group0, forced_bank0_group0}
        : (stack_group == 2'h1) ? {forced_bank1_group1, forced_bank0_group1}
        : (stack_group == 2'h2) ? {forced_bank1_group2, forced_bank0_group2}
        : {forced_bank1_group3, forced_bank0_group3};
    // Upper bank bits are reserved and held at zero
    wire [2:0] bank_unused = 3'h0;
    wire [`MRR_BANK_W-1:0] bank_num = {bank_unused, stack_bank_hi, forced_bank};

    // ==========================================
    // Response FIFO between steer and port slices
    // FIFO word: corrected data, destination, bank number, subsection
    wire [FW-1:0] fifo_in = {fixed_word, stack_wdata_dest, bank_num, stack_ss};
    wire [FW-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_in_ready;
    // Responses for another port are not ours to stall
    assign stack_ready = for_me ? fifo_in_ready : 1'b1;
    // Eight entries absorb a burst while the CPU resumes every other cycle
    mrr_fifo #(.WIDTH(FW), .DEPTH(`MRR_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(take),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_out)
    );

    // ==========================================
    // Port slice: two halves, separate strobes
    logic lo_pend;
    logic hi_pend;
    wire [`MRR_WORD_W-1:0] w = fifo_out[FW-1 -: `MRR_WORD_W];
    wire [`MRR_DEST_W-1:0] d = fifo_out[`MRR_BANK_W+`MRR_SS_W +: `MRR_DEST_W];
    wire [`MRR_BANK_W-1:0] b = fifo_out[`MRR_SS_W +: `MRR_BANK_W];
    wire [`MRR_SS_W-1:0] s = fifo_out[`MRR_SS_W-1:0];

    // 64 data bits and 12 check bits, split evenly over the halves
    wire [31:0] lo_data_bits = w[`MRR_LO_DATA_LSB +: 32];
    wire [31:0] hi_data_bits = w[`MRR_HI_DATA_LSB +: 32];
    wire [5:0] lo_chk_bits = w[`MRR_LO_CHK_LSB +: 6];
    wire [5:0] hi_chk_bits = w[`MRR_HI_CHK_LSB +: 6];
    wire [`MRR_HALF_W-1:0] next_lo_data = {lo_chk_bits, lo_data_bits};
    wire [`MRR_HALF_W-1:0] next_hi_data = {hi_chk_bits, hi_data_bits};
    wire [`MRR_DEST_HALF_W-1:0] next_lo_dest = d[`MRR_DEST_HALF_W-1:0];
    wire [`MRR_DEST_HALF_W-1:0] next_hi_dest = d[`MRR_DEST_W-1:`MRR_DEST_HALF_W];
    wire [2:0] next_lo_bank = b[2:0];
    wire [3:0] next_hi_bank = b[6:3];
    wire [1:0] next_lo_ss = s[1:0];
    wire [1:0] next_hi_ss = s[3:2];

    wire lo_free = !lo_pend || link.lo_resume;
    wire hi_free = !hi_pend || link.hi_resume;
    // Load only when both halves can take a word, keeping them aligned
    assign fifo_ready = lo_free && hi_free;
    wire load = fifo_ready && fifo_valid;
    // A half stays pending until its own resume comes back
    wire next_lo_pend = load || (lo_pend && !link.lo_resume);
    wire next_hi_pend = load || (hi_pend && !link.hi_resume);

    // ==========================================
    // Link registers, one short block per pair
    // Data stands between loads so a slow half still sees its word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lo_pend <= 1'b0;
            hi_pend <= 1'b0;
        end else begin
            lo_pend <= next_lo_pend;
            hi_pend <= next_hi_pend;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.lo_valid <= 1'b0;
            link.hi_valid <= 1'b0;
        end else begin
            link.lo_valid <= load;
            link.hi_valid <= load;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.lo_data <= '0;
            link.hi_data <= '0;
        end else if (load) begin
            link.lo_data <= next_lo_data;
            link.hi_data <= next_hi_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.lo_dest <= '0;
            link.hi_dest <= '0;
        end else if (load) begin
            link.lo_dest <= next_lo_dest;
            link.hi_dest <= next_hi_dest;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.lo_bank <= '0;
            link.hi_bank <= '0;
        end else if (load) begin
            link.lo_bank <= next_lo_bank;
            link.hi_bank <= next_hi_bank;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.lo_ss <= '0;
            link.hi_ss <= '0;
        end else if (load) begin
            link.lo_ss <= next_lo_ss;
            link.hi_ss <= next_hi_ss;
        end
    end
endmodule // mrr_mem_return

// ---- mrr_map.svh ----
// Constants for the memory read return path
`ifndef MRR_MAP_SVH
`define MRR_MAP_SVH
`define MRR_WORD_W 76
`define MRR_HALF_W 38
`define MRR_DEST_W 14
`define MRR_DEST_HALF_W 7
`define MRR_BANK_W 7
`define MRR_SS_W 4
`define MRR_PORTS 4
`define MRR_FIFO_DEPTH 8
`define MRR_LO_DATA_LSB 0
`define MRR_HI_DATA_LSB 32
`define MRR_LO_CHK_LSB 64
`define MRR_HI_CHK_LSB 70
`define MRR_SPARE_NONE 7'h7f
`endif

// ---- mrr_pkg.sv ----
// Types for the memory read return path
`include "mrr_map.svh"
package mrr_pkg;
    typedef logic [`MRR_WORD_W-1:0] mrr_word_t;
    typedef logic [`MRR_HALF_W-1:0] mrr_half_t;
    typedef logic [`MRR_DEST_HALF_W-1:0] mrr_dhalf_t;
    typedef logic [1:0] mrr_rpath_t;
    typedef logic [1:0] mrr_group_t;
    typedef logic [6:0] mrr_spare_t;
    typedef logic [`MRR_BANK_W-1:0] mrr_bank_t;
    typedef logic [`MRR_SS_W-1:0] mrr_ss_t;
endpackage

// ---- mrr_link_if.sv ----
// Link between the memory return path and one CPU port
`timescale 1ns/1ps
interface mrr_link_if;
    import mrr_pkg::*;
    logic lo_valid;
    logic hi_valid;
    logic lo_resume;
    logic hi_resume;
    mrr_half_t lo_data;
    mrr_half_t hi_data;
    mrr_dhalf_t lo_dest;
    mrr_dhalf_t hi_dest;
    logic [2:0] lo_bank;
    logic [3:0] hi_bank;
    logic [1:0] lo_ss;
    logic [1:0] hi_ss;
    modport mem (output lo_valid, hi_valid, lo_data, hi_data, lo_dest, hi_dest,
                 lo_bank, hi_bank, lo_ss, hi_ss, input lo_resume, hi_resume);
    modport cpu (input lo_valid, hi_valid, lo_data, hi_data, lo_dest, hi_dest,
                 lo_bank, hi_bank, lo_ss, hi_ss, output lo_resume, hi_resume);
endinterface

// ---- mrr_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module mrr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
            if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
            count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule // mrr_fifo

// ---- mrr_cpu_receive.sv ----
// CPU end: reassembles the two response halves
`timescale 1ns/1ps
`include "mrr_map.svh"
module mrr_cpu_receive (
    input wire logic clock,
    input wire logic sys_rst,
    mrr_link_if.cpu link,
    output logic word_valid,
    output mrr_pkg::mrr_word_t word_data,
    output logic [`MRR_DEST_W-1:0] word_dest,
    output mrr_pkg::mrr_bank_t word_bank,
    output mrr_pkg::mrr_ss_t word_ss
);
    import mrr_pkg::*;

    // ==========================================
    // Capture both halves and resume each
    wire both = link.lo_valid && link.hi_valid;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            word_valid <= 1'b0;
            word_data <= '0;
            word_dest <= '0;
            word_bank <= '0;
            word_ss <= '0;
            link.lo_resume <= 1'b0;
            link.hi_resume <= 1'b0;
        end else begin
            word_valid <= both;
            link.lo_resume <= link.lo_valid;
            link.hi_resume <= link.hi_valid;
            if (both) begin
                word_data <= {link.hi_data[37:32], link.lo_data[37:32],
                              link.hi_data[31:0], link.lo_data[31:0]};
                word_dest <= {link.hi_dest, link.lo_dest};
                word_bank <= {link.hi_bank, link.lo_bank};
                word_ss <= {link.hi_ss, link.lo_ss};
            end
        end
    end
endmodule // mrr_cpu_receive

// ---- mrr_link_asserts.sv ----
// Checker for the link between the memory end and the CPU end
`timescale 1ns/1ps
module mrr_link_asserts (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic lo_valid,
    input wire logic hi_valid,
    input wire logic lo_resume,
    input wire logic hi_resume,
    input wire mrr_pkg::mrr_half_t lo_data,
    input wire mrr_pkg::mrr_half_t hi_data,
    input wire logic [3:0] hi_bank
);
    import mrr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ====================
    // Link properties
    a_halves_paired: assert property (lo_valid == hi_valid)
        else $error("halves not in step");
    a_bank_top_zero: assert property (hi_valid |-> hi_bank[3:1] == 3'h0)
        else $error("bank bits four to six not zero");
    a_valid_pulse: assert property (lo_valid |=> !lo_valid && !hi_valid)
        else $error("valid longer than one cycle");
    a_resume_follows: assert property (lo_valid |=> lo_resume && hi_resume)
        else $error("no resume after valid");
    a_resume_pair: assert property (lo_resume == hi_resume)
        else $error("resumes not in step");
    a_resume_cause: assert property (lo_resume |-> $past(lo_valid))
        else $error("resume without valid");
    a_data_held: assert property (lo_valid |=> $stable(lo_data) && $stable(hi_data))
        else $error("data moved under resume");
    // Reset release must leave the link quiet
    a_reset_quiet: assert property ($fell(sys_rst) |-> !lo_valid && !hi_valid)
        else $error("valid right after reset");
endmodule // mrr_link_asserts

// ---- memory_read_return_path_test.sv ----
// Testbench for the memory read return path, both ends
`timescale 1ns/1ps
`include "mrr_map.svh"
module memory_read_return_path_test;
    import mrr_pkg::*;
    typedef struct packed {mrr_word_t w; mrr_group_t g; logic [1:0] b; mrr_ss_t s;
        logic [`MRR_DEST_W-1:0] d; mrr_bank_t e;} mrr_row_t;
    mrr_row_t rows [4] = '{
        '{76'hf0123456789abcdef01, 2'h0, 2'h3, 4'h5, 14'h2a55, 7'h0c},
        '{76'ha5a5a5a5a5a5a5a5a5a, 2'h1, 2'h0, 4'ha, 14'h1234, 7'h01},
        '{76'h3c3c3c3c3c3c3c3c3c3, 2'h2, 2'h1, 4'h3, 14'h3fff, 7'h06},
        '{76'hfffffffffffffffffff, 2'h3, 2'h2, 4'hc, 14'h0001, 7'h0b}};
    mrr_row_t cur = '0;
    mrr_row_t r;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic stack_valid = 1'b0;
    logic stack_ready, word_valid, seen, burst = 1'b0, full_seen = 1'b0;
    mrr_rpath_t rp = 2'h0;
    mrr_spare_t spare = `MRR_SPARE_NONE;
    mrr_word_t word_data;
    logic [`MRR_DEST_W-1:0] word_dest;
    mrr_bank_t word_bank;
    mrr_ss_t word_ss;
    logic [7:0] rx = 8'h0;
    int n_errors = 0, n_compared = 0, cycles = 0;
    mrr_link_if link();
    mrr_mem_return #(.PORT_ID(2'h0)) i_mrr_mem_return (.clock(clock), .sys_rst(sys_rst),
        .stack_valid(stack_valid), .stack_ready(stack_ready), .stack_word(cur.w),
        .stack_group(cur.g), .stack_bank_hi(cur.b), .stack_rpath(rp), .stack_ss(cur.s),
        .stack_wdata_dest(cur.d), .spare_pos(spare), .link(link));
    mrr_cpu_receive i_mrr_cpu_receive (.clock(clock), .sys_rst(sys_rst), .link(link),
        .word_valid(word_valid), .word_data(word_data), .word_dest(word_dest),
        .word_bank(word_bank), .word_ss(word_ss));
    mrr_link_asserts i_mrr_link_asserts (.clock(clock), .sys_rst(sys_rst),
        .lo_valid(link.lo_valid), .hi_valid(link.hi_valid), .lo_resume(link.lo_resume),
        .hi_resume(link.hi_resume), .lo_data(link.lo_data), .hi_data(link.hi_data),
        .hi_bank(link.hi_bank));
    always #20 clock = ~clock;
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Valid stays up after the take so bursts run one word per cycle
    task automatic send(input mrr_row_t x);
        @(negedge clock);
        cur = x;
        stack_valid = 1'b1;
        while (stack_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
    endtask
    task automatic get(output logic s);
        s = 1'b0;
        for (int k = 0; k < 12 && !s; k++) begin
            @(negedge clock);
            stack_valid = 1'b0;
            s = (word_valid === 1'b1);
        end
    endtask
    always @(posedge clock) begin
        cycles++;
        full_seen <= full_seen | (stack_valid & (stack_ready === 1'b0));
        if (cycles == 3000) begin
            n_errors++;
            final_report;
        end
    end
    always @(negedge clock) begin
        if (burst && word_valid === 1'b1) begin
            chk(word_data[7:0] === rx, "burst order");
            rx <= rx + 8'h1;
        end
    end
    initial begin
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        chk(stack_ready === 1'b1 && word_valid === 1'b0, "idle after reset");
        foreach (rows[i]) begin
            send(rows[i]);
            get(seen);
            chk(seen && word_data === rows[i].w && word_dest === rows[i].d, "word");
            chk(word_bank === rows[i].e && word_ss === rows[i].s, "bank");
        end
        rp = 2'h2;
        send(rows[0]);
        get(seen);
        chk(!seen, "foreign return path delivered");
        rp = 2'h0;
        spare = 7'h28;
        send(rows[1]);
        get(seen);
        chk(seen && word_data[74:40] === rows[1].w[75:41], "spare shift");
        chk(word_data[39:0] === rows[1].w[39:0], "below spare");
        spare = `MRR_SPARE_NONE;
        @(negedge clock);
        burst = 1'b1;
        for (int i = 0; i < 24; i++) begin
            r = rows[2];
            r.w[7:0] = i[7:0];
            send(r);
        end
        @(negedge clock);
        stack_valid = 1'b0;
        repeat (60) @(negedge clock);
        chk(full_seen === 1'b1 && rx === 8'd24, "fill and drain");
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        chk(stack_ready === 1'b1 && word_valid === 1'b0, "idle after second reset");
        final_report;
    end
endmodule // memory_read_return_path_test
